/* rtl/holding_brake_sequencer.sv */
// Brake sequencer: shapes the speed setpoint and drives the brake.
// Assumes all inputs synchronous to clk; open loop, so the
// shaped setpoint stands in for the motor speed.
`timescale 1ns/1ns
`default_nettype none
module holding_brake_sequencer #(
   parameter int MS_CYC = brake_seq_pkg::MS_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic signed [15:0]        speed_request,
   input  wire logic                      run_enable,
   input  wire logic [15:0]               ramp_step,
   input  wire logic                      cfg_write,
   input  wire brake_seq_pkg::brake_cfg_t cfg_in,
   input  wire logic                      load_defaults,
   input  wire logic [15:0]               motor_slip_speed,
   input  wire logic                      power_stage_active,
   input  wire logic                      brake_assign_req,
   input  wire logic                      brake_assign_value,
   input  wire logic                      motor_contactor_control,
   output logic signed [15:0]             setpoint_out,
   output logic                           brake_release,
   output logic                           contactor_on,
   output logic                           control_active,
   output logic                           assign_refused,
   output logic                           brake_output_function,
   output brake_seq_pkg::brake_cfg_t      cfg_out
);
   import brake_seq_pkg::*;

   // Step cur toward tgt by at most step
   function automatic logic signed [15:0] approach(
      input logic signed [15:0] cur,
      input logic signed [15:0] tgt,
      input logic [15:0]        step);
      logic signed [17:0] d;
      logic signed [17:0] s;
      d = 18'(tgt) - 18'(cur);
      s = $signed({2'b00, step});
      if (d > s) begin
         approach = 16'(18'(cur) + s);
      end else if (d < -s) begin
         approach = 16'(18'(cur) - s);
      end else begin
         approach = tgt;
      end
   endfunction

   // Saturate a wide value into [lo, hi]
   function automatic logic signed [15:0] clamp(
      input logic signed [17:0] v,
      input logic signed [15:0] lo,
      input logic signed [15:0] hi);
      if (v < 18'(lo)) begin
         clamp = lo;
      end else if (v > 18'(hi)) begin
         clamp = hi;
      end else begin
         clamp = 16'(v);
      end
   endfunction

   seq_state_t         state_reg;
   seq_state_t         state_next;
   brake_cfg_t         cfg_reg;
   brake_cfg_t         cfg_next;
   brake_cfg_t         cfg_clamped;
   brake_cfg_t         cfg_default;
   logic               dir_reg;
   logic               dir_next;
   logic signed [15:0] setpoint_reg;
   logic signed [15:0] setpoint_next;
   logic [16:0]        pre_reg;
   logic [15:0]        ms_reg;
   logic               func_reg;
   logic               refused_reg;
   logic               brake_reg;
   logic               ctrl_reg;
   logic               cont_reg;

   // Write path: clamp thresholds and hysteresis into their legal range; delays pass unchanged
   // (R01) threshold ranges
   assign cfg_clamped.cw  = clamp(18'(cfg_in.cw), 16'sh0000, CW_MAX);
   assign cfg_clamped.ccw = clamp(18'(cfg_in.ccw), CCW_MIN, 16'sh0000);
   // (R02) hysteresis range
   assign cfg_clamped.hys = 16'(clamp($signed({2'b00, cfg_in.hys}),
                                      $signed(HYS_MIN), $signed(HYS_MAX)));
   assign cfg_clamped.rel_dly = cfg_in.rel_dly;
   assign cfg_clamped.app_dly = cfg_in.app_dly;
   assign cfg_clamped.con_dly = cfg_in.con_dly;

   // (R09) slip based defaults
   assign cfg_default.cw  = clamp($signed({2'b00, motor_slip_speed}), 16'sh0000, CW_MAX);
   assign cfg_default.ccw = -cfg_default.cw;
   assign cfg_default.hys = (motor_slip_speed[15:1] == 15'h0000) ? HYS_MIN
                          : 16'(clamp($signed({3'b000, motor_slip_speed[15:1]}),
                                      $signed(HYS_MIN), $signed(HYS_MAX)));
   assign cfg_default.rel_dly = cfg_reg.rel_dly;
   assign cfg_default.app_dly = cfg_reg.app_dly;
   assign cfg_default.con_dly = cfg_reg.con_dly;

   // Defaults win over a write in the same cycle
   assign cfg_next = load_defaults ? cfg_default
                   : cfg_write ? cfg_clamped : cfg_reg;

   // Direction compares on the stopped request
   wire logic signed [15:0] eff_req = run_enable ? speed_request : 16'sh0000;
   wire logic signed [17:0] hys_w   = $signed({2'b00, cfg_reg.hys});
   // (R12) signed compare per direction
   wire logic start_cw  = 18'(eff_req) > (18'(cfg_reg.cw) + hys_w);
   wire logic start_ccw = 18'(eff_req) < (18'(cfg_reg.ccw) - hys_w);
   wire logic signed [15:0] thr = dir_reg ? cfg_reg.ccw : cfg_reg.cw;
   wire logic stop_req = dir_reg ? (eff_req > cfg_reg.ccw) : (eff_req < cfg_reg.cw);
   wire logic signed [15:0] sp_thr = approach(setpoint_reg, thr, ramp_step);
   wire logic signed [15:0] sp_run = approach(setpoint_reg, eff_req, ramp_step);

   // Delay of the running wait state, in ms
   wire logic [15:0] cur_dly = (state_reg == ST_REL_HOLD) ? cfg_reg.rel_dly
                             : (state_reg == ST_APP_HOLD) ? cfg_reg.app_dly
                             : cfg_reg.con_dly;
   wire logic time_up = ms_reg >= cur_dly;
   wire logic ms_tick = pre_reg == 17'(MS_CYC - 1);

   // Sequencer
   always_comb begin
      state_next    = state_reg;
      dir_next      = dir_reg;
      setpoint_next = setpoint_reg;
      case (state_reg)
         ST_IDLE: begin
            setpoint_next = 16'sh0000;
            if (start_cw || start_ccw) begin
               dir_next   = start_ccw;
               // (R11) contactor delay before control
               state_next = motor_contactor_control ? ST_CONTACT : ST_ACCEL;
            end
         end
         ST_CONTACT: begin
            if (time_up) begin
               state_next = ST_ACCEL;
            end
         end
         // (R03) ramp only up to threshold
         ST_ACCEL: begin
            setpoint_next = sp_thr;
            if (sp_thr == thr) begin
               state_next = ST_REL_HOLD;
            end
         end
         // (R04) hold during release delay
         ST_REL_HOLD: begin
            setpoint_next = thr;
            if (time_up) begin
               state_next = ST_RUN;
            end
         end
         // (R05) ramp toward request
         ST_RUN: begin
            setpoint_next = sp_run;
            if (stop_req) begin
               state_next    = ST_DECEL;
               setpoint_next = sp_thr;
            end
         end
         // (R06) brake at threshold
         ST_DECEL: begin
            setpoint_next = sp_thr;
            if (!stop_req) begin
               state_next    = ST_RUN;
               setpoint_next = sp_run;
            end else if (sp_thr == thr) begin
               state_next = ST_APP_HOLD;
            end
         end
         // (R07) hold during apply delay
         ST_APP_HOLD: begin
            setpoint_next = thr;
            if (time_up) begin
               setpoint_next = 16'sh0000;
               state_next    = motor_contactor_control ? ST_CON_OFF : ST_IDLE;
            end
         end
         // (R11) contactor delay after control
         ST_CON_OFF: begin
            setpoint_next = 16'sh0000;
            if (time_up) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next    = ST_IDLE;
            setpoint_next = 16'sh0000;
         end
      endcase
   end

   // Output levels follow the next state, so all move together
   wire logic rel_next  = (state_next == ST_REL_HOLD) || (state_next == ST_RUN)
                       || (state_next == ST_DECEL);
   wire logic ctrl_next = (state_next != ST_IDLE) && (state_next != ST_CONTACT)
                       && (state_next != ST_CON_OFF);
   wire logic cont_next = motor_contactor_control ? (state_next != ST_IDLE) : ctrl_next;

   // (R10) reassign only with stage inactive
   wire logic assign_ok = brake_assign_req && !power_stage_active;
   wire logic func_next = assign_ok ? brake_assign_value : func_reg;

   // Timer restarts on every state change for a full first ms
   always_ff @(posedge clk) begin
      if (!rstn || state_next != state_reg) begin
         pre_reg <= 17'h00000;
         ms_reg  <= 16'h0000;
      end else if (ms_tick) begin
         pre_reg <= 17'h00000;
         ms_reg  <= (ms_reg == 16'hFFFF) ? ms_reg : ms_reg + 16'h0001;
      end else begin
         pre_reg <= pre_reg + 17'h00001;
      end
   end

   // Configuration and sequencer registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_reg      <= '{CW_DEF, CCW_DEF, HYS_DEF, DELAY_DEF, DELAY_DEF, CON_DEF};
         state_reg    <= ST_IDLE;
         dir_reg      <= 1'b0;
         setpoint_reg <= 16'sh0000;
      end else begin
         cfg_reg      <= cfg_next;
         state_reg    <= state_next;
         dir_reg      <= dir_next;
         setpoint_reg <= setpoint_next;
      end
   end

   // Drive side outputs; brake only acts if the output is assigned
   always_ff @(posedge clk) begin
      if (!rstn) begin
         func_reg    <= 1'b0;
         refused_reg <= 1'b0;
         brake_reg   <= 1'b0;
         ctrl_reg    <= 1'b0;
         cont_reg    <= 1'b0;
      end else begin
         func_reg    <= func_next;
         refused_reg <= brake_assign_req && power_stage_active;
         brake_reg   <= rel_next && func_next;
         ctrl_reg    <= ctrl_next;
         cont_reg    <= cont_next;
      end
   end

   assign setpoint_out          = setpoint_reg;
   assign brake_release         = brake_reg;
   assign contactor_on          = cont_reg;
   assign control_active        = ctrl_reg;
   assign assign_refused        = refused_reg;
   assign brake_output_function = func_reg;
   assign cfg_out               = cfg_reg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_rel_entry;
      (state_reg == ST_ACCEL) ##1 (state_reg == ST_REL_HOLD);
   endsequence

   a_thr_range: assert property ( // (R01)
      cfg_reg.cw >= 16'sh0000 && cfg_reg.cw <= CW_MAX
      && cfg_reg.ccw <= 16'sh0000 && cfg_reg.ccw >= CCW_MIN)
      else $error("threshold out of range");
   a_hys_range: assert property ( // (R02)
      cfg_reg.hys >= HYS_MIN && cfg_reg.hys <= HYS_MAX)
      else $error("hysteresis out of range");
   a_accel_cap: assert property ( // (R03)
      state_reg == ST_ACCEL && !dir_reg |-> setpoint_reg <= cfg_reg.cw)
      else $error("accel passed threshold");
   a_rel_entry: assert property ( // (R03)
      s_rel_entry |-> setpoint_reg == thr && control_active)
      else $error("release not at threshold");
   a_rel_hold: assert property ( // (R04)
      state_reg == ST_REL_HOLD && $past(state_reg) == ST_REL_HOLD
      |-> setpoint_reg == $past(setpoint_reg))
      else $error("setpoint moved in release hold");
   a_rel_time: assert property ( // (R04)
      state_reg == ST_REL_HOLD && state_next == ST_RUN |-> ms_reg >= cfg_reg.rel_dly)
      else $error("release delay cut short");
   // Squares taken 36 bits wide, a 16 bit product would wrap
   a_run_dir: assert property ( // (R05)
      state_reg == ST_RUN && $stable(eff_req) && $past(state_reg) == ST_RUN
      |-> (36'(setpoint_reg) - 36'(eff_req)) * (36'(setpoint_reg) - 36'(eff_req))
          <= (36'($past(setpoint_reg)) - 36'(eff_req)) * (36'($past(setpoint_reg)) - 36'(eff_req)))
      else $error("run ramp moved away");
   a_apply_thr: assert property ( // (R06)
      $fell(brake_release) && $past(state_reg) == ST_DECEL |-> setpoint_reg == thr)
      else $error("brake applied off threshold");
   a_apply_hold: assert property ( // (R07)
      state_reg == ST_APP_HOLD |-> !brake_release && control_active && setpoint_reg == thr)
      else $error("apply hold broken");
   a_defaults: assert property ( // (R09)
      load_defaults && motor_slip_speed <= 16'h0FFF
      |=> cfg_reg.cw == 16'($past(motor_slip_speed))
          && cfg_reg.ccw == -cfg_reg.cw)
      else $error("defaults not from slip");
   a_assign_lock: assert property ( // (R10)
      power_stage_active |=> brake_output_function == $past(brake_output_function))
      else $error("brake output changed online");
   a_contactor: assert property ( // (R11)
      motor_contactor_control && $rose(control_active) |-> contactor_on)
      else $error("control before contactor");
   a_dir_pick: assert property ( // (R12)
      state_reg == ST_IDLE && start_cw |=> !dir_reg)
      else $error("wrong direction picked");
endmodule
`default_nettype wire

/* rtl/brake_seq_pkg.sv */
// Constants, types and states of the holding brake sequencer.
// Assumes one 100 MHz clock; speeds in rpm, signed 16 bit.
// Contract
// (R01) Separate cw and ccw thresholds, clamped ranges
// (R02) Hysteresis 1..32764 added before release
// (R03) Accelerate to threshold, then release brake
// (R04) Hold threshold until release delay expires
// (R05) Then ramp to the requested setpoint
// (R06) Below threshold: decelerate, apply at threshold
// (R07) Hold threshold until apply delay expires
// (R08) Configurer matches delays to brake times
// (R09) Defaults: slip speed, hysteresis half slip
// (R10) Brake output reassignment only while stage inactive
// (R11) Contactor delay around brake sequence when linked
// (R12) Signed compare, direction picks threshold
package brake_seq_pkg;
   localparam int SPD_W = 16;
   localparam logic signed [15:0] CW_MAX  = 16'sh7FFC;
   localparam logic signed [15:0] CW_DEF  = 16'sh005A;
   localparam logic signed [15:0] CCW_MIN = 16'sh8004;
   localparam logic signed [15:0] CCW_DEF = 16'shFFA6;
   localparam logic [15:0] HYS_MIN   = 16'h0001;
   localparam logic [15:0] HYS_MAX   = 16'h7FFC;
   localparam logic [15:0] HYS_DEF   = 16'h0001;
   localparam logic [15:0] DELAY_DEF = 16'h0064;
   localparam logic [15:0] CON_DEF   = 16'h0064;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic signed [15:0] cw;
      logic signed [15:0] ccw;
      logic [15:0]        hys;
      logic [15:0]        rel_dly;
      logic [15:0]        app_dly;
      logic [15:0]        con_dly;
   } brake_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_CONTACT  = 3'h1,
      ST_ACCEL    = 3'h2,
      ST_REL_HOLD = 3'h3,
      ST_RUN      = 3'h4,
      ST_DECEL    = 3'h5,
      ST_APP_HOLD = 3'h6,
      ST_CON_OFF  = 3'h7
   } seq_state_t;
endpackage

/* tb/brake_model.sv */
// Behavioural model of the holding brake on the brake output.
// Assumes brake_release is a registered level in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module brake_model #(
   parameter int REL_CYC = 15,
   parameter int APP_CYC = 15
) (
   input  wire logic clk,
   input  wire logic brake_release,
   output logic      brake_open
);
   logic [7:0] age_reg  = 8'hFF;
   logic       last_reg = 1'b0;
   logic       open_reg = 1'b0;

   // Cycles since the command last changed, saturating
   // Case compare so an unknown command before reset cannot freeze the count
   always @(posedge clk) begin
      last_reg <= brake_release;
      age_reg  <= (brake_release !== last_reg) ? 8'h01 : ((age_reg == 8'hFF) ? age_reg : age_reg + 8'h01);
   end

   // brake mechanical times
   // Opening and closing both take time, so the hold delays must cover them
   always @(posedge clk) begin
      if (brake_release === 1'b1 && age_reg >= 8'(REL_CYC)) begin
         open_reg <= 1'b1;
      end else if (brake_release === 1'b0 && age_reg >= 8'(APP_CYC)) begin
         open_reg <= 1'b0;
      end
   end

   assign brake_open = open_reg;
endmodule
`default_nettype wire

/* tb/holding_brake_sequencer_tb_top.sv */
// Self-checking bench for the brake sequencer with a brake model.
// Assumes MS_CYC of 10, so one ms lasts 10 clocks.
`timescale 1ns/1ns
`default_nettype none
module holding_brake_sequencer_tb_top;
   import brake_seq_pkg::*;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic signed [15:0] speed_request = 16'sh0000;
   logic              run_enable = 1'b0;
   logic              cfg_write = 1'b0;
   logic              load_defaults = 1'b0;
   logic [15:0]       motor_slip_speed = 16'h00C8;
   logic              power_stage_active = 1'b0;
   logic              brake_assign_req = 1'b0;
   logic              brake_assign_value = 1'b0;
   logic              motor_contactor_control = 1'b0;
   logic [15:0]       ramp_step = 16'h001E; // Several steps up to threshold
   brake_cfg_t        cfg_in = '0;
   brake_cfg_t        cfg_out;
   logic signed [15:0] setpoint_out;
   logic              brake_release, contactor_on, control_active;
   logic              assign_refused, brake_output_function, brake_open;
   int                fail_count = 0;
   int                comparisons = 0;

   holding_brake_sequencer #(.MS_CYC(10)) dut_u (.clk(clk), .rstn(rstn), .speed_request(speed_request),
      .run_enable(run_enable), .ramp_step(ramp_step), .cfg_write(cfg_write), .cfg_in(cfg_in),
      .load_defaults(load_defaults), .motor_slip_speed(motor_slip_speed),
      .power_stage_active(power_stage_active), .brake_assign_req(brake_assign_req),
      .brake_assign_value(brake_assign_value), .motor_contactor_control(motor_contactor_control),
      .setpoint_out(setpoint_out), .brake_release(brake_release), .contactor_on(contactor_on),
      .control_active(control_active), .assign_refused(assign_refused),
      .brake_output_function(brake_output_function), .cfg_out(cfg_out));
   brake_model #(.REL_CYC(15), .APP_CYC(15)) brake_u (.clk(clk), .brake_release(brake_release),
      .brake_open(brake_open));

   always #5 clk = ~clk;

   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Selector picks which output a wait or count looks at
   function automatic logic hit(input int sel, input logic signed [15:0] t);
      case (sel)
         0: return brake_release === t[0];
         1: return control_active === t[0];
         2: return contactor_on === t[0];
         default: return setpoint_out === t;
      endcase
   endfunction

   task automatic wt(input int sel, input logic signed [15:0] t);
      int i;
      for (i = 0; i < 400 && !hit(sel, t); i++) @(negedge clk);
      if (i == 400) begin
         fail_count++;
         tally_and_finish();
      end
   endtask

   task automatic cnt(input int sel, input logic signed [15:0] t, output logic [15:0] ok);
      int n;
      n = 0;
      while (hit(sel, t) && n < 200) begin
         n++;
         @(negedge clk);
      end
      ok = 16'(n >= 20 && n <= 23);
   endtask

   // One-cycle pulse on a config strobe
   task automatic pulse_cfg(input brake_cfg_t c, input logic dflt);
      cfg_in = c;
      cfg_write = ~dflt;
      load_defaults = dflt;
      @(negedge clk);
      cfg_write = 1'b0;
      load_defaults = 1'b0;
      @(negedge clk);
   endtask

   task automatic cfg_test();
      chk("rst_cfg", 16'h005A, cfg_out.cw);
      chk("rst_ccw", 16'hFFA6, cfg_out.ccw);
      chk("rst_hys", HYS_DEF, cfg_out.hys);
      chk("rst_rel", 16'h0064, cfg_out.rel_dly);
      chk("rst_app", 16'h0064, cfg_out.app_dly);
      chk("rst_con", 16'h0064, cfg_out.con_dly);
      pulse_cfg({16'sh7FFF, 16'sh0005, 16'h0000, 16'h1234, 16'h0000, 16'h0001}, 1'b0);
      chk("clamp_cw", CW_MAX, cfg_out.cw);
      chk("clamp_ccw", 16'h0000, cfg_out.ccw);
      chk("clamp_hys", HYS_MIN, cfg_out.hys);
      chk("keep_rel", 16'h1234, cfg_out.rel_dly);
      pulse_cfg(cfg_out, 1'b1);
      chk("dflt_cw", 16'h00C8, cfg_out.cw);
      chk("dflt_ccw", 16'hFF38, cfg_out.ccw);
      chk("dflt_hys", 16'h0064, cfg_out.hys);
      // Short delays: 2 ms holds, 2 ms contactor lead
      pulse_cfg({16'sh005A, 16'shFFA6, 16'h0001, 16'h0002, 16'h0002, 16'h0002}, 1'b0);
   endtask

   task automatic assign_test();
      power_stage_active = 1'b1;
      brake_assign_value = 1'b1;
      brake_assign_req = 1'b1;
      @(negedge clk);
      chk("refused", 16'h0001, 16'(assign_refused));
      chk("func_kept", 16'h0000, 16'(brake_output_function));
      // Request stays up; only the stage goes inactive
      power_stage_active = 1'b0;
      @(negedge clk);
      brake_assign_req = 1'b0;
      chk("func_set", 16'h0001, 16'(brake_output_function));
      chk("not_refused", 16'h0000, 16'(assign_refused));
   endtask

   // Full release, run and apply cycle in one direction
   task automatic seq(input logic signed [15:0] req, input logic signed [15:0] thr, input logic link);
      logic [15:0] ok;
      motor_contactor_control = link;
      speed_request = req;
      run_enable = 1'b1;
      if (link) begin
         wt(2, 16'sh0001);
         cnt(1, 16'sh0000, ok);
         chk("con_lead_len", 16'h0001, ok);
         chk("con_lead", 16'h0001, 16'(hit(1, 16'sh0001)));
      end
      wt(0, 16'sh0001);
      chk("sp_release", thr, setpoint_out);
      cnt(3, thr, ok);
      chk("rel_hold", 16'h0001, ok);
      chk("brake_open", 16'h0001, 16'(brake_open));
      wt(3, req);
      chk("sp_run", req, setpoint_out);
      run_enable = 1'b0;
      wt(0, 16'sh0000);
      chk("sp_apply", thr, setpoint_out);
      cnt(1, 16'sh0001, ok);
      chk("app_hold", 16'h0001, ok);
      chk("sp_stop", 16'h0000, setpoint_out);
      chk("brake_closed", 16'h0000, 16'(brake_open));
      if (link) begin
         chk("con_trail", 16'h0001, 16'(contactor_on));
         wt(2, 16'sh0000);
      end
      speed_request = 16'sh0000;
      @(negedge clk);
   endtask

   // Request equal to threshold plus hysteresis must not start
   task automatic edge_test();
      speed_request = 16'sh005B;
      run_enable = 1'b1;
      repeat (20) @(negedge clk);
      chk("no_start", 16'h0000, 16'(control_active));
      run_enable = 1'b0;
      @(negedge clk);
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      cfg_test();
      assign_test();
      edge_test();
      seq(16'sh01F4, 16'sh005A, 1'b0);
      seq(-16'sh01F4, -16'sh005A, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
